// ==== adc_trigger_sequencer_bench.sv ====
// Self-checking bench joining both converter trigger ends
`timescale 1ns/100ps
module adc_trigger_sequencer_bench;
  import atsq_pkg::*;
  logic clock = 1'b0;  // System clock
  logic reset = 1'b1;  // Sync reset
  logic power_on = 1'b0;  // User configuration
  logic trigger_pwm = 1'b0;
  logic pwm_duty_source = 1'b0;
  logic [1:0] duty_channel = 2'h0;
  logic [DLY_W-1:0] delay_count = 8'h00;
  logic [DIV_W-1:0] divide_select = 3'h0;
  logic amp_input = 1'b0;
  logic [1:0] bound_mode = 2'h0;
  logic [RES_W-1:0] upper_limit = 12'h0c8;
  logic [RES_W-1:0] lower_limit = 12'h064;
  logic done_irq_en = 1'b1;
  logic bound_irq_en = 1'b1;
  logic start_req = 1'b0;  // User requests
  logic clear_done = 1'b0;
  logic clear_bound = 1'b0;
  logic pwm_period_event = 1'b0;
  logic [1:0] pwm_duty_event = 2'h0;
  logic [RES_W-1:0] core_result = 12'h000;  // Analog core answer
  logic ready, busy, done, bound;  // User status
  logic core_power, core_sampling, conv_clock;  // Analog core controls
  logic [RES_W-1:0] result;
  int bad_count = 0;
  int tests_run = 0;
  atsq_if lk ();
  atsq_dev atsq_dev_inst (.clock, .reset, .clock_enable(1'b1), .link(lk), .core_result,
    .core_power, .core_sampling, .conv_clock);
  atsq_sw atsq_sw_inst (.clock, .reset, .clock_enable(1'b1), .link(lk), .power_on, .trigger_pwm,
    .pwm_duty_source, .duty_channel, .delay_count, .divide_select, .amp_input, .bound_mode,
    .upper_limit, .lower_limit, .done_irq_en, .bound_irq_en, .start_req, .clear_done,
    .clear_bound, .pwm_period_event, .pwm_duty_event, .ready, .busy, .done, .bound, .result);
  atsq_monitor atsq_monitor_inst (.clock, .reset,
    .converter_power_enable(lk.converter_power_enable), .start_bit(lk.start_bit),
    .trigger_source_select(lk.trigger_source_select),
    .pwm_event_source_select(lk.pwm_event_source_select),
    .duty_channel_select(lk.duty_channel_select), .delay_start_enable(lk.delay_start_enable),
    .delay_count_value(lk.delay_count_value), .clock_divide_select(lk.clock_divide_select),
    .amplifier_select(lk.amplifier_select), .bound_compare_mode(lk.bound_compare_mode),
    .upper_bound(lk.upper_bound), .lower_bound(lk.lower_bound),
    .pwm_period_event_flag(lk.pwm_period_event_flag), .pwm_duty_event_flag(lk.pwm_duty_event_flag),
    .conversion_busy_flag(lk.conversion_busy_flag), .done_flag(lk.done_flag),
    .bound_flag(lk.bound_flag), .result_word(lk.result_word));
  // Clock at 125 MHz
  always #4 clock = ~clock;
  // Verdict and end of run
  task automatic test_done;
    if (bad_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done
  // Compare and count
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask : check
  // Count falling edges until busy on the link reaches a level
  task automatic wait_lvl(input logic lvl, input int lim, output int n);
    n = 0;
    while (lk.conversion_busy_flag !== lvl && n < lim) begin
      @(negedge clock);
      n++;
    end
  endtask : wait_lvl
  // Clear flags, then one software started conversion
  task automatic run_sw(input logic [RES_W-1:0] res, output int w);
    int n;
    clear_done = 1'b1;
    clear_bound = 1'b1;
    @(negedge clock);
    clear_done = 1'b0;
    clear_bound = 1'b0;
    repeat (3) @(negedge clock);
    check("done cleared", 0, done);
    core_result = res;
    start_req = 1'b1;
    @(negedge clock);
    start_req = 1'b0;
    wait_lvl(1'b1, 50, n);
    check("sampling", 1, core_sampling);
    check("conv clock", divide_select != 3'h1, conv_clock);
    wait_lvl(1'b0, 3000, w);
    repeat (3) @(negedge clock);
  endtask : run_sw
  // Every divide code, length, result and completion
  task automatic t_sw;
    int w;
    int t;
    for (int d = 0; d < 8; d++) begin
      divide_select = d[2:0];
      repeat (2) @(negedge clock);
      t = 16 << d;
      run_sw(12'h5a0 + d[11:0], w);
      check("busy width", t - 1, w);
      check("result", 12'h5a0 + d, result);
      check("done", 1, done);
      check("done irq", 1, lk.done_irq);
    end
  endtask : t_sw
  // Triggers while converting are dropped
  task automatic t_refuse;
    int n;
    int w;
    divide_select = 3'h3;
    repeat (2) @(negedge clock);
    start_req = 1'b1;
    @(negedge clock);
    start_req = 1'b0;
    wait_lvl(1'b1, 50, n);
    start_req = 1'b1;
    pwm_period_event = 1'b1;
    @(negedge clock);
    start_req = 1'b0;
    pwm_period_event = 1'b0;
    wait_lvl(1'b0, 3000, w);
    wait_lvl(1'b1, 40, n);
    check("restart gap", 40, n);
    divide_select = 3'h0;
  endtask : t_refuse
  // PWM trigger with source, channel and delay
  task automatic t_pwm(input logic tp, input logic ds, input logic [1:0] ch, input logic [7:0] dly,
      input logic pe, input logic [1:0] de, input int exp);
    int n;
    int w;
    trigger_pwm = tp;
    pwm_duty_source = ds;
    duty_channel = ch;
    delay_count = dly;
    repeat (3) @(negedge clock);
    pwm_period_event = pe;
    pwm_duty_event = de;
    @(negedge clock);
    pwm_period_event = 1'b0;
    pwm_duty_event = 2'h0;
    wait_lvl(1'b1, 300, n);
    check("pwm start cycles", exp, n + 1);
    wait_lvl(1'b0, 3000, w);
    repeat (3) @(negedge clock);
  endtask : t_pwm
  // Bound compare for one mode and result
  task automatic t_bnd(input logic amp, input logic [1:0] m, input logic [11:0] r, input logic e);
    int w;
    amp_input = amp;
    bound_mode = m;
    repeat (2) @(negedge clock);
    run_sw(r, w);
    check("bound flag", e, bound);
    check("bound irq", e, lk.bound_irq);
  endtask : t_bnd
  // Main sequence
  initial begin
    repeat (8) @(negedge clock);
    reset = 1'b0;
    power_on = 1'b1;
    for (int i = 0; i < 300 && ready !== 1'b1; i++) @(negedge clock);
    check("ready", 1, ready);
    check("core power", 1, core_power);
    t_sw();
    t_refuse();
    t_pwm(1'b1, 1'b0, 2'h0, 8'h00, 1'b1, 2'h0, 3);
    t_pwm(1'b1, 1'b0, 2'h0, 8'h05, 1'b1, 2'h0, 8);
    t_pwm(1'b1, 1'b0, 2'h0, 8'hff, 1'b1, 2'h0, 258);
    t_pwm(1'b1, 1'b1, 2'h0, 8'h00, 1'b0, 2'h1, 3);
    t_pwm(1'b1, 1'b1, 2'h1, 8'h02, 1'b0, 2'h2, 5);
    t_pwm(1'b1, 1'b1, 2'h1, 8'h00, 1'b0, 2'h1, 301);
    t_pwm(1'b1, 1'b1, 2'h2, 8'h00, 1'b0, 2'h3, 301);
    t_pwm(1'b1, 1'b1, 2'h0, 8'h00, 1'b1, 2'h0, 301);
    t_pwm(1'b0, 1'b0, 2'h0, 8'h00, 1'b1, 2'h3, 301);
    trigger_pwm = 1'b0;
    t_bnd(1'b1, 2'h0, 12'h096, 1'b1);
    t_bnd(1'b1, 2'h0, 12'h0c8, 1'b0);
    t_bnd(1'b1, 2'h1, 12'h064, 1'b1);
    t_bnd(1'b1, 2'h1, 12'h065, 1'b0);
    t_bnd(1'b1, 2'h2, 12'h0c8, 1'b1);
    t_bnd(1'b1, 2'h2, 12'h0c7, 1'b0);
    t_bnd(1'b1, 2'h3, 12'h0fa, 1'b1);
    t_bnd(1'b0, 2'h3, 12'h032, 1'b0);
    test_done();
  end
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    test_done();
  end
endmodule : adc_trigger_sequencer_bench

// ==== atsq_dev.sv ====
// Converter control end: trigger choice, delay, clock divide, busy, flags
`timescale 1ns/100ps
module atsq_dev (
  // Clocking
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  // Link to software and PWM end
  atsq_if.dev link,
  // Analog core side
  input wire logic [atsq_pkg::RES_W-1:0] core_result,
  output logic core_power,
  output logic core_sampling,
  output logic conv_clock
);
  import atsq_pkg::*;

  // Bound condition test on a finished result
  function automatic logic bound_hit(input logic [1:0] mode, input logic [RES_W-1:0] v,
                                     input logic [RES_W-1:0] lo, input logic [RES_W-1:0] hi);
    case (mode)
      BOUND_INSIDE: bound_hit = (v > lo) && (v < hi);
      BOUND_LOW: bound_hit = (v <= lo);
      BOUND_HIGH: bound_hit = (v >= hi);
      default: bound_hit = (v <= lo) || (v >= hi);
    endcase
  endfunction : bound_hit

  // System clocks in one conversion clock period, minus one
  function automatic logic [PER_W-1:0] period_last(input logic [DIV_W-1:0] sel);
    period_last = PER_W'((9'h001 << sel) - 9'h001);
  endfunction : period_last

  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_CONVERT} atsq_state_e;

  atsq_state_e state_r;  // Sequencer state
  logic start_seen_r;  // Start bit has been high
  logic start_prev_r;  // Start bit one cycle ago
  logic event_prev_r;  // Selected PWM event one cycle ago
  logic [DLY_W-1:0] delay_r;  // Remaining delay clocks
  logic [PER_W-1:0] per_cnt_r;  // System clocks inside conversion clock
  logic [PER_W-1:0] per_last_r;  // Divide latched at start
  logic [ADCK_W-1:0] adck_r;  // Conversion clocks done
  logic busy_r;  // Busy flag
  logic done_r;  // Done flag
  logic bound_r;  // Bound flag
  logic done_irq_r;  // Done interrupt request
  logic bound_irq_r;  // Bound interrupt request
  logic [RES_W-1:0] result_r;  // Last result
  logic sampling_r;  // Sampling phase out
  logic conv_clock_r;  // Conversion clock out
  logic power_r;  // Power enable out
  logic pwm_event;  // Selected PWM event level
  logic event_rise;  // Rising edge of it
  logic sw_trigger;  // Completed start sequence
  logic pwm_now;  // PWM trigger without delay
  logic begin_conv;  // Conversion starts this cycle
  logic adck_tick;  // Last system clock of a conversion clock
  logic end_conv;  // Conversion ends this cycle

  // Pick the PWM event from period or duty channel
  always_comb begin
    pwm_event = 1'b0;
    if (link.pwm_event_source_select == PWM_SRC_PERIOD) begin
      pwm_event = link.pwm_period_event_flag;
    end else begin
      case (link.duty_channel_select)
        DUTY_CH0: pwm_event = link.pwm_duty_event_flag[0];
        DUTY_CH1: pwm_event = link.pwm_duty_event_flag[1];
        default: pwm_event = 1'b0;  // Reserved channels never trigger
      endcase
    end
  end

  // Trigger qualification and conversion start
  assign event_rise = pwm_event && !event_prev_r;
  assign sw_trigger = (link.trigger_source_select == TRIG_SOFTWARE)
                      && start_seen_r && start_prev_r && !link.start_bit;
  assign pwm_now = (link.trigger_source_select == TRIG_PWM) && event_rise
                   && !(link.delay_start_enable && (link.delay_count_value != DELAY_RESET));
  assign adck_tick = (state_r == ST_CONVERT) && (per_cnt_r == per_last_r);
  assign end_conv = adck_tick && (adck_r == TOTAL_PERIODS - 5'h01);
  assign begin_conv = link.converter_power_enable && (state_r == ST_IDLE) && (sw_trigger
                      || pwm_now);

  // Start bit history; sequence rearms once a low is seen
  always_ff @(posedge clock) begin
    if (reset) begin
      start_prev_r <= 1'b0;
      start_seen_r <= 1'b0;
    end else if (clock_enable) begin
      start_prev_r <= link.start_bit;
      if (link.start_bit && !start_prev_r) begin
        start_seen_r <= 1'b1;
      end else if (!link.start_bit) begin
        start_seen_r <= 1'b0;
      end
    end
  end

  // PWM event edge detector
  always_ff @(posedge clock) begin
    if (reset) begin
      event_prev_r <= 1'b0;
    end else if (clock_enable) begin
      event_prev_r <= pwm_event;
    end
  end

  // Sequencer: idle, optional delay, conversion
  always_ff @(posedge clock) begin
    if (reset) begin
      state_r <= ST_IDLE;
      delay_r <= DELAY_RESET;
    end else if (clock_enable) begin
      case (state_r)
        ST_IDLE: begin
          if (begin_conv) begin
            state_r <= ST_CONVERT;
          end else if (link.converter_power_enable && (link.trigger_source_select == TRIG_PWM)
                       && event_rise && link.delay_start_enable) begin
            state_r <= ST_DELAY;
            delay_r <= link.delay_count_value;
          end
        end
        ST_DELAY: begin
          // Events here are dropped; delay ends after count clocks
          if (!link.converter_power_enable) begin
            state_r <= ST_IDLE;
          end else if (delay_r == 8'h01) begin
            state_r <= ST_CONVERT;
          end else begin
            delay_r <= delay_r - 8'h01;
          end
        end
        ST_CONVERT: begin
          // New triggers are ignored until the end
          if (!link.converter_power_enable || end_conv) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Conversion clock divider and period count
  always_ff @(posedge clock) begin
    if (reset) begin
      per_cnt_r <= '0;
      per_last_r <= '0;
      adck_r <= '0;
      conv_clock_r <= 1'b0;
    end else if (clock_enable) begin
      if (state_r != ST_CONVERT) begin
        per_cnt_r <= '0;
        per_last_r <= period_last(link.clock_divide_select);
        adck_r <= '0;
        conv_clock_r <= 1'b0;
      end else if (adck_tick) begin
        per_cnt_r <= '0;
        adck_r <= adck_r + 5'h01;
        conv_clock_r <= 1'b1;
      end else begin
        per_cnt_r <= per_cnt_r + 8'h01;
        // High for the first half of each conversion clock period
        conv_clock_r <= (per_cnt_r + 8'h01) <= (per_last_r >> 1);
      end
    end
  end

  // Busy flag and sampling phase
  always_ff @(posedge clock) begin
    if (reset) begin
      busy_r <= 1'b0;
      sampling_r <= 1'b0;
    end else if (clock_enable) begin
      busy_r <= (state_r == ST_CONVERT) && link.converter_power_enable
                && !end_conv;
      sampling_r <= (state_r == ST_CONVERT) && link.converter_power_enable
                    && (adck_r < SAMPLE_PERIODS) && !end_conv;
    end
  end

  // Result capture, completion flags, set wins over clear
  always_ff @(posedge clock) begin
    if (reset) begin
      result_r <= RESULT_RESET;
      done_r <= 1'b0;
      bound_r <= 1'b0;
    end else if (clock_enable) begin
      if (end_conv && link.converter_power_enable) begin
        result_r <= core_result;
        done_r <= 1'b1;
        if (link.amplifier_select && bound_hit(link.bound_compare_mode, core_result,
                                                link.lower_bound, link.upper_bound)) begin
          bound_r <= 1'b1;
        end else if (link.bound_flag_clear) begin
          bound_r <= 1'b0;
        end
      end else begin
        if (link.done_flag_clear) begin
          done_r <= 1'b0;
        end
        if (link.bound_flag_clear) begin
          bound_r <= 1'b0;
        end
      end
    end
  end

  // Interrupt requests gated by their enables
  always_ff @(posedge clock) begin
    if (reset) begin
      done_irq_r <= 1'b0;
      bound_irq_r <= 1'b0;
      power_r <= 1'b0;
    end else if (clock_enable) begin
      done_irq_r <= done_r && link.done_irq_enable;
      bound_irq_r <= bound_r && link.bound_irq_enable;
      power_r <= link.converter_power_enable;
    end
  end

  // Outputs straight from flops
  assign link.conversion_busy_flag = busy_r;
  assign link.done_flag = done_r;
  assign link.bound_flag = bound_r;
  assign link.done_irq = done_irq_r;
  assign link.bound_irq = bound_irq_r;
  assign link.result_word = result_r;
  assign core_power = power_r;
  assign core_sampling = sampling_r;
  assign conv_clock = conv_clock_r;
endmodule : atsq_dev

// ==== atsq_if.sv ====
// Interface joining the software and PWM end to the converter control end
`timescale 1ns/100ps
interface atsq_if;
  import atsq_pkg::*;
  logic converter_power_enable;  // Control fields from software
  logic start_bit;
  logic trigger_source_select;
  logic pwm_event_source_select;
  logic [1:0] duty_channel_select;
  logic delay_start_enable;
  logic [DLY_W-1:0] delay_count_value;
  logic [DIV_W-1:0] clock_divide_select;
  logic amplifier_select;
  logic [1:0] bound_compare_mode;
  logic [RES_W-1:0] upper_bound;
  logic [RES_W-1:0] lower_bound;
  logic done_irq_enable;
  logic bound_irq_enable;
  logic done_flag_clear;
  logic bound_flag_clear;
  logic pwm_period_event_flag;  // PWM event flags
  logic [1:0] pwm_duty_event_flag;
  logic conversion_busy_flag;  // Status back to software
  logic done_flag;
  logic bound_flag;
  logic done_irq;
  logic bound_irq;
  logic [RES_W-1:0] result_word;
  modport dev (
    input converter_power_enable, start_bit, trigger_source_select,
    input pwm_event_source_select, duty_channel_select, delay_start_enable,
    input delay_count_value, clock_divide_select, amplifier_select,
    input bound_compare_mode, upper_bound, lower_bound, done_irq_enable,
    input bound_irq_enable, done_flag_clear, bound_flag_clear,
    input pwm_period_event_flag, pwm_duty_event_flag,
    output conversion_busy_flag, done_flag, bound_flag, done_irq, bound_irq,
    output result_word
  );
  modport sw (
    output converter_power_enable, start_bit, trigger_source_select,
    output pwm_event_source_select, duty_channel_select, delay_start_enable,
    output delay_count_value, clock_divide_select, amplifier_select,
    output bound_compare_mode, upper_bound, lower_bound, done_irq_enable,
    output bound_irq_enable, done_flag_clear, bound_flag_clear,
    output pwm_period_event_flag, pwm_duty_event_flag,
    input conversion_busy_flag, done_flag, bound_flag, done_irq, bound_irq,
    input result_word
  );
endinterface : atsq_if

// ==== atsq_monitor.sv ====
// Concurrent checks on the link between the two converter trigger ends
`timescale 1ns/100ps
module atsq_monitor (
  // Clocking
  input wire logic clock,
  input wire logic reset,
  // Control fields
  input wire logic converter_power_enable,
  input wire logic start_bit,
  input wire logic trigger_source_select,
  input wire logic pwm_event_source_select,
  input wire logic [1:0] duty_channel_select,
  input wire logic delay_start_enable,
  input wire logic [atsq_pkg::DLY_W-1:0] delay_count_value,
  input wire logic [atsq_pkg::DIV_W-1:0] clock_divide_select,
  input wire logic amplifier_select,
  input wire logic [1:0] bound_compare_mode,
  input wire logic [atsq_pkg::RES_W-1:0] upper_bound,
  input wire logic [atsq_pkg::RES_W-1:0] lower_bound,
  // PWM events
  input wire logic pwm_period_event_flag,
  input wire logic [1:0] pwm_duty_event_flag,
  // Status
  input wire logic conversion_busy_flag,
  input wire logic done_flag,
  input wire logic bound_flag,
  input wire logic [atsq_pkg::RES_W-1:0] result_word
);
  import atsq_pkg::*;
  logic per_q;  // Period flag one cycle back
  logic [1:0] duty_q;  // Duty flags one cycle back
  logic sel_rise;  // Selected event just rose
  logic bmatch;  // Result meets bound condition
  logic [11:0] busy_len;  // Cycles busy has stood
  logic [11:0] conv_len;  // Expected conversion length
  logic [8:0] since_ev;  // Cycles since a taken event
  logic [8:0] want_ev;  // Expected event to busy count
  default clocking @(posedge clock);
  endclocking
  default disable iff (reset);
  // Event levels one cycle back
  always_ff @(posedge clock) begin
    per_q <= reset ? 1'b0 : pwm_period_event_flag;
    duty_q <= reset ? 2'h0 : pwm_duty_event_flag;
  end
  // Rise of the event the selects point at
  always_comb begin
    if (!pwm_event_source_select) begin
      sel_rise = pwm_period_event_flag && !per_q;
    end else if (!duty_channel_select[1]) begin
      sel_rise = pwm_duty_event_flag[duty_channel_select[0]] && !duty_q[duty_channel_select[0]];
    end else begin
      sel_rise = 1'b0;  // Reserved channels
    end
  end
  // Bound condition per mode
  always_comb begin
    case (bound_compare_mode)
      BOUND_INSIDE: bmatch = result_word > lower_bound && result_word < upper_bound;
      BOUND_LOW: bmatch = result_word <= lower_bound;
      BOUND_HIGH: bmatch = result_word >= upper_bound;
      default: bmatch = result_word <= lower_bound || result_word >= upper_bound;
    endcase
  end
  // Busy length and time since a taken event
  always_ff @(posedge clock) begin
    busy_len <= (reset || !conversion_busy_flag) ? 12'h000 : busy_len + 12'h001;
    if (reset) begin
      since_ev <= 9'h1ff;
    end else if (trigger_source_select && sel_rise && !conversion_busy_flag) begin
      since_ev <= 9'h000;
    end else if (since_ev != 9'h1ff) begin
      since_ev <= since_ev + 9'h001;
    end
  end
  assign conv_len = 12'h010 << clock_divide_select;
  assign want_ev = (delay_start_enable && delay_count_value != 8'h00) ?
      {1'b0, delay_count_value} + 9'h001 : 9'h001;
  chk_soft_start:
    assert property ($fell(start_bit) && !trigger_source_select && converter_power_enable
        && !conversion_busy_flag |-> ##2 conversion_busy_flag) else $error("software start lost");
  chk_no_stray_start:
    assert property (!trigger_source_select && !conversion_busy_flag && !$past(start_bit)
        && !$past(start_bit, 2) |=> !conversion_busy_flag) else $error("busy rose without a start");
  chk_pwm_taken:
    assert property (trigger_source_select && sel_rise && !conversion_busy_flag
        && converter_power_enable && want_ev == 9'h001 |-> ##2 conversion_busy_flag)
    else $error("pwm event not taken");
  chk_pwm_delay:
    assert property ($rose(conversion_busy_flag) && trigger_source_select |-> since_ev == want_ev)
    else $error("pwm start delay wrong");
  chk_busy_length:
    assert property ($fell(conversion_busy_flag) && converter_power_enable
        |-> busy_len == conv_len || busy_len == conv_len - 12'h001) else $error("busy length wrong");
  chk_done_at_end:
    assert property ($fell(conversion_busy_flag) && converter_power_enable |-> done_flag)
    else $error("done flag missing at end");
  chk_bound_hit:
    assert property ($fell(conversion_busy_flag) && converter_power_enable && amplifier_select
        && bmatch |-> bound_flag) else $error("bound flag missing");
  chk_bound_gate:
    assert property ($rose(bound_flag) |-> amplifier_select && bmatch && $past(conversion_busy_flag))
    else $error("bound flag without cause");
  cov_soft_start: cover property ($fell(start_bit) ##2 conversion_busy_flag);
  cov_delayed: cover property ($rose(conversion_busy_flag) && since_ev > 9'h001);
  cov_bound: cover property ($rose(bound_flag));
endmodule : atsq_monitor

// ==== atsq_pkg.sv ====
// Constants for the converter trigger sequencer, shared by both ends
// What this block does
// - Software start or PWM event, one selected
// - Start bit low-high-low starts one conversion
// - PWM period or duty event, by select bit
// - Duty channel select picks duty event source
// - Optional delay of count system clocks
// - Software keeps delay count consistent with enable
// - Busy set at start, cleared at end
// - Done flag set; interrupt when enabled
// - Result checked against bounds, flag raised
// - Conversion clock is system clock over 1..128
// - Software picks legal conversion clock divide
// - Power enable needed; software starts wait for settling, PWM triggers do not
// - Software clears power enable when idle; atsq_sw follows power_on even while busy
// - Sixteen conversion clocks: four sample, twelve convert
// - Bound mode codes; only for amplifier input
// - Delay counts from event flag rising edge
package atsq_pkg;
  localparam int RES_W = 12;  // Result width
  localparam int DLY_W = 8;  // Delay count width
  localparam int DIV_W = 3;  // Divide select width
  localparam int PER_W = 8;  // Conversion clock period counter width
  localparam int ADCK_W = 5;  // Conversion clock count width
  localparam logic [ADCK_W-1:0] SAMPLE_PERIODS = 5'h04;  // Sampling part
  localparam logic [ADCK_W-1:0] CONVERT_PERIODS = 5'h0c;  // Conversion part
  localparam logic [ADCK_W-1:0] TOTAL_PERIODS = SAMPLE_PERIODS + CONVERT_PERIODS;
  localparam logic TRIG_SOFTWARE = 1'b0;  // Trigger source select codes
  localparam logic TRIG_PWM = 1'b1;
  localparam logic PWM_SRC_PERIOD = 1'b0;  // PWM event source select codes
  localparam logic PWM_SRC_DUTY = 1'b1;
  localparam logic [1:0] DUTY_CH0 = 2'h0;  // Duty channel select codes
  localparam logic [1:0] DUTY_CH1 = 2'h1;
  localparam logic [1:0] BOUND_INSIDE = 2'h0;  // Bound compare mode codes
  localparam logic [1:0] BOUND_LOW = 2'h1;
  localparam logic [1:0] BOUND_HIGH = 2'h2;
  localparam logic [1:0] BOUND_EITHER = 2'h3;
  localparam logic [DLY_W-1:0] DELAY_RESET = 8'h00;  // Reset values
  localparam logic [DIV_W-1:0] DIVIDE_RESET = 3'h0;
  localparam logic [RES_W-1:0] RESULT_RESET = 12'h000;
  localparam int CLK_PERIOD_PS = 8000;  // System clock period
  localparam int SETTLE_NS = 1000;  // Settling time after power enable
  localparam int SETTLE_CYCLES = (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SETTLE_W = 8;  // Settling counter width
endpackage : atsq_pkg

// ==== atsq_sw.sv ====
// Software and PWM end: drives control fields, start sequence, events
`timescale 1ns/100ps
module atsq_sw (
  // Clocking
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  // Link to converter control end
  atsq_if.sw link,
  // Configuration from the user
  input wire logic power_on,
  input wire logic trigger_pwm,
  input wire logic pwm_duty_source,
  input wire logic [1:0] duty_channel,
  input wire logic [atsq_pkg::DLY_W-1:0] delay_count,
  input wire logic [atsq_pkg::DIV_W-1:0] divide_select,
  input wire logic amp_input,
  input wire logic [1:0] bound_mode,
  input wire logic [atsq_pkg::RES_W-1:0] upper_limit,
  input wire logic [atsq_pkg::RES_W-1:0] lower_limit,
  input wire logic done_irq_en,
  input wire logic bound_irq_en,
  // Requests from the user
  input wire logic start_req,
  input wire logic clear_done,
  input wire logic clear_bound,
  input wire logic pwm_period_event,
  input wire logic [1:0] pwm_duty_event,
  // Status to the user
  output logic ready,
  output logic busy,
  output logic done,
  output logic bound,
  output logic [atsq_pkg::RES_W-1:0] result
);
  import atsq_pkg::*;

  logic [SETTLE_W-1:0] settle_r;  // Settling clocks counted so far

  // Power enable and settling wait before starts are allowed
  always_ff @(posedge clock) begin
    if (reset) begin
      link.converter_power_enable <= 1'b0;
      settle_r <= '0;
      ready <= 1'b0;
    end else if (clock_enable) begin
      link.converter_power_enable <= power_on;
      if (!power_on) begin
        settle_r <= '0;
        ready <= 1'b0;
      end else if (settle_r == SETTLE_W'(SETTLE_CYCLES)) begin
        ready <= 1'b1;
      end else begin
        settle_r <= settle_r + 8'h01;
      end
    end
  end

  // Configuration fields straight onto the link; delay count zero when delay is off
  always_ff @(posedge clock) begin
    if (reset) begin
      link.trigger_source_select <= TRIG_SOFTWARE;
      link.pwm_event_source_select <= PWM_SRC_PERIOD;
      link.duty_channel_select <= DUTY_CH0;
      link.delay_start_enable <= 1'b0;
      link.delay_count_value <= DELAY_RESET;
      link.clock_divide_select <= DIVIDE_RESET;
      link.amplifier_select <= 1'b0;
      link.bound_compare_mode <= BOUND_INSIDE;
      link.upper_bound <= RESULT_RESET;
      link.lower_bound <= RESULT_RESET;
      link.done_irq_enable <= 1'b0;
      link.bound_irq_enable <= 1'b0;
    end else if (clock_enable) begin
      link.trigger_source_select <= trigger_pwm;
      link.pwm_event_source_select <= pwm_duty_source;
      link.duty_channel_select <= duty_channel;
      link.delay_start_enable <= (delay_count != DELAY_RESET);
      link.delay_count_value <= delay_count;
      link.clock_divide_select <= divide_select;
      link.amplifier_select <= amp_input;
      link.bound_compare_mode <= bound_mode;
      link.upper_bound <= upper_limit;
      link.lower_bound <= lower_limit;
      link.done_irq_enable <= done_irq_en;
      link.bound_irq_enable <= bound_irq_en;
    end
  end

  // Start bit pulse, one cycle high, then low
  always_ff @(posedge clock) begin
    if (reset) begin
      link.start_bit <= 1'b0;
    end else if (clock_enable) begin
      link.start_bit <= start_req && ready && !link.start_bit && !trigger_pwm;
    end
  end

  // Event flags, clear pulses and status copies
  always_ff @(posedge clock) begin
    if (reset) begin
      link.pwm_period_event_flag <= 1'b0;
      link.pwm_duty_event_flag <= 2'h0;
      link.done_flag_clear <= 1'b0;
      link.bound_flag_clear <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      bound <= 1'b0;
      result <= RESULT_RESET;
    end else if (clock_enable) begin
      link.pwm_period_event_flag <= pwm_period_event;
      link.pwm_duty_event_flag <= pwm_duty_event;
      link.done_flag_clear <= clear_done;
      link.bound_flag_clear <= clear_bound;
      busy <= link.conversion_busy_flag;
      done <= link.done_flag;
      bound <= link.bound_flag;
      result <= link.result_word;
    end
  end
endmodule : atsq_sw
